// ---- pfs_port_fault.v ----
// Fault status latch and host command register of a port controller.
// Assumes a simple synchronous register port, inputs synchronous to clk.
// What this block does
// - Power-loss flag is one after a power reset.
// - Software reset leaves the power-loss flag unchanged.
// - Set auto drain fault when enabled drain misses its deadline.
// - Set forced drain fault when low stop level drain fails.
// - Latch cable supply over-current flag on detection.
// - Sink transmit with fewer than two bytes sets host error.
// - Flags stay set until software writes one to them.
// - Command register resets to zero and clears after processing.
// - Wake command only wakes the host port.
// - Detection-off command stops presence detection; while sourcing or sinking it is ignored and sets host error.
// - Detection-on command starts presence detection.
// - Draw-off command stops sinking, detection kept.
// - Draw-on enables sinking and presence detection.
// - Draw-on while sourcing is ignored and sets host error.
`timescale 1ns/1ns
`include "pfs_map.vh"
module pfs_port_fault (
  input wire clk,
  input wire rst_b,
  input wire soft_reset_cmd,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  input wire auto_drain_enable,
  input wire forced_drain_enable,
  input wire drain_stop_at_safe0,
  input wire disconnect_seen,
  input wire drain_deadline_miss,
  input wire forced_drain_miss,
  input wire cable_oc_detect,
  input wire sink_transmit_req,
  input wire [7:0] send_byte_count,
  input wire source_enabled,
  input wire bus_power_sense,
  output wire bus_power_present,
  output wire presence_detect_enable,
  output wire power_draw_enable,
  output wire wake_host_port
);
  localparam CMD_IDLE = 1'b0;
  localparam CMD_EXEC = 1'b1;
  reg [7:0] fault_q;
  reg [7:0] fault_d;
  reg [7:0] cmd_q;
  reg cmd_state_q;
  reg auto_armed_q;
  wire reject_pulse;
  wire exec_rst_b;
  wire cmd_busy;
  wire wr_fault;
  wire wr_cmd;
  wire auto_fail_evt;
  wire forced_fail_evt;
  wire cable_oc_evt;
  wire host_err_evt;

  // True when a register access targets the given offset.
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Clears the flags written with one; zero bits and reserved bits stay.
  function [7:0] w1c_clear;
    input [7:0] flags;
    input [7:0] wdata;
    begin
      w1c_clear = flags & ~(wdata & `PFS_FAULT_MASK);
    end
  endfunction

  // A sink transmit with too few buffered bytes is a host access error.
  function tx_too_short;
    input req;
    input [7:0] count;
    begin
      tx_too_short = req && (count < `PFS_MIN_SEND_BYTES);
    end
  endfunction

  // Software reset restores the defaults but keeps the power-loss flag.
  function [7:0] soft_keep;
    input [7:0] flags;
    begin
      soft_keep = `PFS_FAULT_RESET;
      soft_keep[`PFS_BIT_POWER_LOSS] = flags[`PFS_BIT_POWER_LOSS];
    end
  endfunction

  // Read data of one access; unmapped offsets read as zero.
  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] flags;
    input [7:0] cmd;
    begin
      if (addr_hit(addr, `PFS_ADDR_FAULT_FLAGS))
        read_mux = flags & `PFS_FAULT_MASK;
      else if (addr_hit(addr, `PFS_ADDR_HOST_COMMAND))
        read_mux = cmd;
      else
        read_mux = 8'h00;
    end
  endfunction

  assign wr_fault = reg_wr && addr_hit(reg_addr, `PFS_ADDR_FAULT_FLAGS);
  assign wr_cmd = reg_wr && addr_hit(reg_addr, `PFS_ADDR_HOST_COMMAND);
  assign exec_rst_b = rst_b && !soft_reset_cmd;
  assign cmd_busy = (cmd_state_q == CMD_EXEC);

  // A deadline miss counts when the watch is armed or when the
  // disconnect arrives in the same cycle.
  assign auto_fail_evt = (auto_armed_q || disconnect_seen) &&
    auto_drain_enable && drain_deadline_miss;
  assign forced_fail_evt = forced_drain_enable && drain_stop_at_safe0 &&
    forced_drain_miss;
  assign cable_oc_evt = cable_oc_detect;
  assign host_err_evt = tx_too_short(sink_transmit_req, send_byte_count) ||
    reject_pulse;

  // The auto drain watch is armed by a disconnect and holds until the
  // deadline result arrives or auto drain is disabled.
  always @(posedge clk)
  begin
    if (!exec_rst_b)
      auto_armed_q <= 1'b0;
    else if (!auto_drain_enable)
      auto_armed_q <= 1'b0;
    else if (disconnect_seen)
      auto_armed_q <= 1'b1;
    else if (drain_deadline_miss)
      auto_armed_q <= 1'b0;
  end

  // The write clear is applied first so that an event in the same cycle
  // as its clear still leaves the flag set.
  always @*
  begin
    fault_d = fault_q;
    if (wr_fault)
      fault_d = w1c_clear(fault_q, reg_wdata);
    if (auto_fail_evt)
      fault_d[`PFS_BIT_AUTO_DRAIN] = 1'b1;
    if (forced_fail_evt)
      fault_d[`PFS_BIT_FORCED_DRAIN] = 1'b1;
    if (cable_oc_evt)
      fault_d[`PFS_BIT_CABLE_OC] = 1'b1;
    if (host_err_evt)
      fault_d[`PFS_BIT_HOST_ERR] = 1'b1;
    fault_d = fault_d & `PFS_FAULT_MASK;
  end

  always @(posedge clk)
  begin
    if (!rst_b)
      fault_q <= `PFS_FAULT_RESET;
    else if (soft_reset_cmd)
      fault_q <= soft_keep(fault_q);
    else
      fault_q <= fault_d;
  end

  // The command is held one cycle for execution, then auto-cleared.
  // A command write that lands during that cycle is refused.
  always @(posedge clk)
  begin
    if (!exec_rst_b)
    begin
      cmd_q <= `PFS_CMD_RESET;
      cmd_state_q <= CMD_IDLE;
    end
    else
    begin
      case (cmd_state_q)
        CMD_IDLE:
        begin
          if (wr_cmd)
          begin
            cmd_q <= reg_wdata;
            cmd_state_q <= CMD_EXEC;
          end
        end
        CMD_EXEC:
        begin
          cmd_q <= `PFS_CMD_RESET;
          cmd_state_q <= CMD_IDLE;
        end
        default:
        begin
          cmd_q <= `PFS_CMD_RESET;
          cmd_state_q <= CMD_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= read_mux(reg_addr, fault_q, cmd_q);
  end

  pfs_cmd_exec u_exec (
    .clk(clk),
    .rst_b(exec_rst_b),
    .cmd_valid(cmd_busy),
    .cmd_code(cmd_q),
    .source_enabled(source_enabled),
    .detect_enable_q(presence_detect_enable),
    .power_draw_q(power_draw_enable),
    .wake_pulse_q(wake_host_port),
    .reject_pulse_q(reject_pulse)
  );

  assign bus_power_present = presence_detect_enable & bus_power_sense;
endmodule // pfs_port_fault

// ---- pfs_map.vh ----
// Register offsets, field positions, reset values and command codes for
// the port fault status and command block.
// Assumes inclusion by bare name from the design files.
`ifndef PFS_MAP_VH
`define PFS_MAP_VH
`define PFS_ADDR_FAULT_FLAGS 8'h1f
`define PFS_ADDR_HOST_COMMAND 8'h23
`define PFS_FAULT_RESET 8'h80
`define PFS_CMD_RESET 8'h00
`define PFS_FAULT_MASK 8'hb3
`define PFS_BIT_POWER_LOSS 7
`define PFS_BIT_AUTO_DRAIN 5
`define PFS_BIT_FORCED_DRAIN 4
`define PFS_BIT_CABLE_OC 1
`define PFS_BIT_HOST_ERR 0
`define PFS_CMD_WAKE 8'h01
`define PFS_CMD_DETECT_OFF 8'h02
`define PFS_CMD_DETECT_ON 8'h03
`define PFS_CMD_DRAW_OFF 8'h04
`define PFS_CMD_DRAW_ON 8'h05
`define PFS_MIN_SEND_BYTES 8'h02
`endif

// ---- pfs_cmd_exec.v ----
// Command executor: decodes one accepted command byte and updates the
// presence detection and sink control state.
// Assumes cmd_valid is a one-cycle strobe from the register block.
`timescale 1ns/1ns
`include "pfs_map.vh"
module pfs_cmd_exec (
  input wire clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire source_enabled,
  output reg detect_enable_q,
  output reg power_draw_q,
  output reg wake_pulse_q,
  output reg reject_pulse_q
);
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      detect_enable_q <= 1'b1;
      power_draw_q <= 1'b0;
      wake_pulse_q <= 1'b0;
      reject_pulse_q <= 1'b0;
    end
    else
    begin
      wake_pulse_q <= 1'b0;
      reject_pulse_q <= 1'b0;
      if (cmd_valid)
      begin
        case (cmd_code)
          `PFS_CMD_WAKE: wake_pulse_q <= 1'b1;
          `PFS_CMD_DETECT_OFF:
          begin
            if (source_enabled || power_draw_q)
              reject_pulse_q <= 1'b1;
            else
              detect_enable_q <= 1'b0;
          end
          `PFS_CMD_DETECT_ON: detect_enable_q <= 1'b1;
          `PFS_CMD_DRAW_OFF: power_draw_q <= 1'b0;
          `PFS_CMD_DRAW_ON:
          begin
            if (source_enabled)
              reject_pulse_q <= 1'b1;
            else
            begin
              power_draw_q <= 1'b1;
              detect_enable_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule // pfs_cmd_exec

// ---- pfs_port_fault_properties.sv ----
// Checker bound to the fault latch and command block.
// Assumes command writes at least two cycles apart.
`timescale 1ns/1ns
module pfs_port_fault_properties (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire source_enabled,
  input wire bus_power_sense,
  input wire bus_power_present,
  input wire presence_detect_enable,
  input wire power_draw_enable,
  input wire wake_host_port
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wc = reg_wr && reg_addr == 8'h23;
  wire [7:0] c = reg_wdata;
  wire pd = presence_detect_enable, dr = power_draw_enable;
  wire bsy = source_enabled || dr;
  property p_rsv; reg_rd && reg_addr == 8'h1f |=> !(reg_rdata_q & 8'h4c);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_pres; bus_power_present == (bus_power_sense && pd);
  endproperty
  a_pres: assert property (p_pres) else $error("present");
  property p_wake; wc && c == 8'h01 |-> ##2 wake_host_port ##1 !wake_host_port;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_on; wc && c == 8'h05 && !source_enabled |-> ##2 dr && pd;
  endproperty
  a_on: assert property (p_on) else $error("draw on");
  property p_rej; wc && c == 8'h05 && source_enabled |-> ##2 dr == $past(dr, 2);
  endproperty
  a_rej: assert property (p_rej) else $error("draw kept");
  property p_off; wc && c == 8'h04 |-> ##2 !dr && pd == $past(pd, 2);
  endproperty
  a_off: assert property (p_off) else $error("draw off");
  property p_doff; wc && c == 8'h02 && !bsy |-> ##2 !pd;
  endproperty
  a_doff: assert property (p_doff) else $error("detect off");
  property p_drej; wc && c == 8'h02 && bsy |-> ##2 pd == $past(pd, 2);
  endproperty
  a_drej: assert property (p_drej) else $error("detect kept");
  property p_undef; wc && c > 8'h05 |=> $stable({dr, pd, wake_host_port}) [*2];
  endproperty
  a_undef: assert property (p_undef) else $error("undefined");
  cover property (wake_host_port);
  cover property (wc && c == 8'h02 && dr);
  cover property (wc && c == 8'h05 && source_enabled);
endmodule // pfs_port_fault_properties
bind pfs_port_fault pfs_port_fault_properties chk_i (.clk, .rst_b, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .source_enabled,
  .bus_power_sense, .bus_power_present, .presence_detect_enable,
  .power_draw_enable, .wake_host_port);

// ---- pfs_host_model.sv ----
// Port manager model issuing register writes and reads.
// Assumes the block samples its register port on the rising edge.
`timescale 1ns/1ns
module pfs_host_model (
  input wire clk,
  input wire [7:0] reg_rdata_q,
  output logic reg_wr = 0,
  output logic reg_rd = 0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task put(input [7:0] a, d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_wdata} = {1'b0, ~d};
    @(negedge clk);
  endtask
  task get(input [7:0] a, output [7:0] d);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 0;
    d = reg_rdata_q;
  endtask
endmodule // pfs_host_model

// ---- pfs_port_fault_tb.sv ----
// Bench for the fault latch and command block.
// Assumes the port manager model drives the register port.
`timescale 1ns/1ns
module pfs_port_fault_tb;
  logic clk = 0, rst_b = 0, soft_reset_cmd = 0, auto_drain_enable = 0;
  logic forced_drain_enable = 0, drain_stop_at_safe0 = 0, disconnect_seen = 0;
  logic drain_deadline_miss = 0, forced_drain_miss = 0, cable_oc_detect = 0;
  logic sink_transmit_req = 0, source_enabled = 0, bus_power_sense = 1;
  logic [7:0] send_byte_count = 8'h00, d;
  wire reg_wr, reg_rd, bus_power_present, presence_detect_enable;
  wire power_draw_enable, wake_host_port;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  int errors = 0, n_compared = 0, wakes = 0, i;
  // Each row: command, source, expected draw, detect and host error.
  logic [11:0] tbl [9] = '{12'h056, 12'h027, 12'h042, 12'h020, 12'h032,
    12'h02b, 12'h05b, 12'h012, 12'h0c2};
  always #25 clk = ~clk;
  always @(negedge clk) if (wake_host_port === 1'b1) wakes++;
  pfs_port_fault uut (.clk, .rst_b, .soft_reset_cmd, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_q, .auto_drain_enable,
    .forced_drain_enable, .drain_stop_at_safe0, .disconnect_seen,
    .drain_deadline_miss, .forced_drain_miss, .cable_oc_detect,
    .sink_transmit_req, .send_byte_count, .source_enabled, .bus_power_sense,
    .bus_power_present, .presence_detect_enable, .power_draw_enable,
    .wake_host_port);
  pfs_host_model host (.clk, .reg_rdata_q, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  task chk(input string n, input [7:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input [7:0] a, e);
    host.get(a, d);
    chk(a == 8'h1f ? "flags" : "command", d, e);
  endtask
  task report_and_stop;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    rd(8'h1f, 8'h80);
    rd(8'h23, 8'h00);
    @(negedge clk) soft_reset_cmd = 1;
    @(negedge clk) soft_reset_cmd = 0;
    rd(8'h1f, 8'h80);
    host.put(8'h1f, 8'h00);
    rd(8'h1f, 8'h80);
    host.put(8'h1f, 8'h80);
    rd(8'h1f, 8'h00);
    @(negedge clk) {cable_oc_detect, auto_drain_enable} = 2'h3;
    @(negedge clk) {cable_oc_detect, disconnect_seen} = 2'h1;
    {forced_drain_enable, drain_stop_at_safe0} = 2'h3;
    @(negedge clk) {disconnect_seen, drain_deadline_miss} = 2'h1;
    @(negedge clk) {drain_deadline_miss, forced_drain_miss} = 2'h1;
    @(negedge clk) {forced_drain_miss, send_byte_count} = 9'h002;
    sink_transmit_req = 1;
    @(negedge clk) sink_transmit_req = 0;
    rd(8'h1f, 8'h32);
    @(negedge clk) {sink_transmit_req, send_byte_count} = 9'h101;
    @(negedge clk) sink_transmit_req = 0;
    host.put(8'h1f, 8'h02);
    rd(8'h1f, 8'h31);
    host.put(8'h1f, 8'hff);
    rd(8'h1f, 8'h00);
    @(negedge clk) {drain_stop_at_safe0, forced_drain_miss} = 2'h1;
    drain_deadline_miss = 1;
    @(negedge clk) {forced_drain_miss, drain_deadline_miss} = 2'h0;
    rd(8'h1f, 8'h00);
    for (i = 0; i < 9; i++)
    begin
      source_enabled = tbl[i][3];
      host.put(8'h23, tbl[i][11:4]);
      repeat (2) @(negedge clk);
      chk("outputs", {power_draw_enable, presence_detect_enable,
        bus_power_present}, {tbl[i][2:1], tbl[i][1]});
      rd(8'h23, 8'h00);
      rd(8'h1f, {7'h0, tbl[i][0]});
      host.put(8'h1f, 8'h01);
    end
    chk("wakes", wakes[7:0], 8'h01);
    @(negedge clk) bus_power_sense = 0;
    @(negedge clk) chk("present", bus_power_present, 1'b0);
    @(negedge clk) soft_reset_cmd = 1;
    @(negedge clk) soft_reset_cmd = 0;
    rd(8'h1f, 8'h00);
    report_and_stop;
  end
endmodule // pfs_port_fault_tb
